// file: logic/umd_pkg.sv
// Constants, field layout and state type of the multidrop serial transceiver
package umd_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 3;
  localparam logic [2:0]  OFF_DATA    = 3'h0;
  localparam logic [2:0]  OFF_CTRL_A  = 3'h1;
  localparam logic [2:0]  OFF_CTRL_B  = 3'h2;
  localparam logic [2:0]  OFF_CTRL_C  = 3'h3;
  localparam logic [2:0]  OFF_BAUD_LO = 3'h4;
  localparam logic [2:0]  OFF_BAUD_HI = 3'h5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_A_RESET = 8'h20;
  localparam logic [7:0]  CTRL_B_RESET = 8'h00;
  localparam logic [7:0]  CTRL_C_RESET = 8'h06;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int A_RXC  = 7;
  localparam int A_TXC  = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE   = 4;
  localparam int A_DOR  = 3;
  localparam int A_PE   = 2;
  localparam int A_U2X  = 1;
  localparam int A_MPCM = 0;
  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN  = 4;
  localparam int B_TXEN  = 3;
  localparam int B_CSZ2  = 2;
  localparam int B_RXB8  = 1;
  localparam int B_TXB8  = 0;
  localparam int C_UPM1  = 5;
  localparam int C_UPM0  = 4;
  localparam int C_USBS  = 3;
  localparam int C_CSZ1  = 2;
  localparam int C_CSZ0  = 1;

  // ----------------------------------------------------------------
  // Sample counts per bit (last count, mid-bit count) and character size constants
  // ----------------------------------------------------------------
  localparam logic [3:0]  OVS_NORMAL_LAST = 4'hf;
  localparam logic [3:0]  OVS_NORMAL_HALF = 4'h7;
  localparam logic [3:0]  OVS_DOUBLE_LAST = 4'h7;
  localparam logic [3:0]  OVS_DOUBLE_HALF = 4'h3;
  localparam logic [2:0]  CSZ_NINE        = 3'h7;
  localparam logic [3:0]  CHAR_BASE       = 4'h5;
  localparam logic [3:0]  CHAR_EIGHT      = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} umd_rx_e;

  typedef struct packed {
    logic [7:0] data;
    logic       ninth;
    logic       fe;
    logic       pe;
  } umd_entry_s;

  typedef struct packed {
    logic             mpcm;
    logic             u2x;
    logic             rxcie;
    logic             txcie;
    logic             udrie;
    logic             rxen;
    logic             txen;
    logic             csz2;
    logic             txb8;
    logic [1:0]       upm;
    logic             usbs;
    logic [1:0]       csz_lo;
    logic [11:0]      baud;
    logic [11:0]      baud_cnt;
    logic             txc;
    logic [7:0]       tx_buffer;
    logic             txb_ninth;
    logic             txb_full;
    logic             tx_own;
    logic             tx_busy;
    logic [12:0]      tx_sh;
    logic [3:0]       tx_left;
    logic [3:0]       tx_samp;
    logic             rx_s1;
    logic             rx_s2;
    umd_rx_e          rx_st;
    logic [3:0]       rx_samp;
    logic [3:0]       rx_idx;
    logic [10:0]      rx_sh;
    logic             rx_drop;
    logic             pend;
    umd_entry_s       pend_e;
    umd_entry_s [1:0] fifo;
    logic [1:0]       cnt;
    logic             dor;
    logic [7:0]       rdata;
  } umd_state_s;

  localparam umd_state_s STATE_RESET = '{
    csz_lo : CTRL_C_RESET[C_CSZ1:C_CSZ0],
    tx_sh  : 13'h1fff,
    rx_s1  : 1'b1,
    rx_s2  : 1'b1,
    rx_st  : RX_IDLE,
    default: '0
  };

endpackage : umd_pkg

// file: logic/umd_serial_core.sv
// Serial transceiver core: data window, status/control, multidrop filter
// ----------------------------------------------------------------
// Operation
// - Filter on: data frames discarded, address frames received; transmitter unaffected.
// - One data address: writes fill transmit buffer, reads return receive front.
// - Short characters: transmitter ignores upper bits, receiver returns them zero.
// - Data write while transmit buffer full is ignored.
// - Enabled transmitter moves buffer into idle shifter and shifts it out.
// - Receive buffer is two-entry FIFO advancing on every data read while it holds data.
// - Receive-complete is one while FIFO holds data; receiver disable flushes.
// - Transmit-complete sets when frame out and buffer empty; cleared by ack or one.
// - Buffer-empty flag is one when buffer accepts data, one after reset.
// - Frame error tracks first stop bit of oldest unread character.
// - Overrun sets on start bit with FIFO full and shifter holding character.
// - Parity error tracks oldest unread character when parity checking enabled.
// - Double-speed bit cuts samples per bit from sixteen to eight.
// - Each interrupt needs its enable, global flag and its status flag.
// - Receiver enable takes receive pin; disable flushes and clears error flags.
// - Transmitter disable waits for shifter and buffer empty, then frees pin.
// - High size bit plus two low bits set character length both ways.
// - Received ninth bit readable; software reads it before the data window.
// - Ninth transmit bit taken with data write; software writes it first.
// - Frame type is first stop bit or ninth bit; one means address.
// - Size codes 000-011 give five to eight bits, 111 gives nine.
// ----------------------------------------------------------------
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module umd_serial_core
  import umd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  input  wire logic              global_irq_en_i,
  input  wire logic              tx_complete_ack_i,
  input  wire logic              serial_rx_pin_i,
  output logic                   serial_tx_pin_o,
  output logic                   serial_tx_oe_o,
  output logic                   serial_rx_own_o,
  output logic                   rx_complete_irq_o,
  output logic                   tx_complete_irq_o,
  output logic                   tx_empty_irq_o
);

  // ----------------------------------------------------------------
  // State and derived values
  // ----------------------------------------------------------------
  umd_state_s  state_reg;
  umd_state_s  state_next;
  logic        nine;
  logic [3:0]  data_bits;
  logic [3:0]  rx_total;
  logic [3:0]  ovs_last;
  logic [3:0]  ovs_half;
  logic        tick;
  logic [7:0]  data_mask;
  logic        wr_data;
  logic        rd_data;
  logic        rxc;
  logic [7:0]  tx_data_m;
  logic        tx_par;
  logic [12:0] frame;
  logic [3:0]  frame_len;
  logic [7:0]  rx_dat;
  logic        rx_b8;
  logic        rx_perr;
  logic        rx_done;
  logic        frame_type;
  logic        keep;
  logic        tx_last;

  assign nine      = {state_reg.csz2, state_reg.csz_lo} == CSZ_NINE;
  assign data_bits = state_reg.csz2 ? CHAR_EIGHT
                                    : ({2'b00, state_reg.csz_lo} + CHAR_BASE);
  assign rx_total  = data_bits + {3'h0, nine} + {3'h0, state_reg.upm[1]};
  assign ovs_last  = state_reg.u2x ? OVS_DOUBLE_LAST : OVS_NORMAL_LAST;
  assign ovs_half  = state_reg.u2x ? OVS_DOUBLE_HALF : OVS_NORMAL_HALF;
  assign tick      = state_reg.baud_cnt == 12'h000;
  assign data_mask = 8'hff >> (CHAR_EIGHT - data_bits);
  assign wr_data   = wr_i && (addr_i == OFF_DATA);
  assign rd_data   = rd_i && (addr_i == OFF_DATA);
  assign rxc       = state_reg.cnt != 2'h0;
  assign tx_data_m = state_reg.tx_buffer & data_mask;
  assign tx_par    = ^tx_data_m ^ (nine & state_reg.txb_ninth) ^ state_reg.upm[0];
  assign tx_last   = state_reg.tx_busy && tick && (state_reg.tx_samp == ovs_last)
                     && (state_reg.tx_left == 4'h1);

  // Receive field extraction
  assign rx_dat     = state_reg.rx_sh[7:0] & data_mask;
  assign rx_b8      = nine & state_reg.rx_sh[data_bits];
  assign rx_perr    = state_reg.upm[1] & (^rx_dat ^ rx_b8 ^ state_reg.upm[0]
                      ^ state_reg.rx_sh[data_bits + {3'h0, nine}]);
  assign rx_done    = state_reg.rxen && (state_reg.rx_st == RX_STOP) && tick
                      && (state_reg.rx_samp == ovs_last);
  assign frame_type = nine ? rx_b8 : state_reg.rx_s2;
  assign keep       = !(state_reg.mpcm && !frame_type) && !state_reg.rx_drop;

  // ----------------------------------------------------------------
  // Transmit frame assembly
  // ----------------------------------------------------------------
  always_comb begin
    logic [3:0] pos;
    pos      = 4'h1;
    frame    = 13'h1fff;
    frame[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(data_bits)) begin
        frame[pos] = tx_data_m[i];
        pos        = pos + 4'h1;
      end
    end
    if (nine) begin
      frame[pos] = state_reg.txb_ninth;
      pos        = pos + 4'h1;
    end
    if (state_reg.upm[1]) begin
      frame[pos] = tx_par;
      pos        = pos + 4'h1;
    end
    frame_len = pos + 4'h1 + {3'h0, state_reg.usbs};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next          = state_reg;
    state_next.rx_s1    = serial_rx_pin_i;
    state_next.rx_s2    = state_reg.rx_s1;
    state_next.baud_cnt = tick ? state_reg.baud : state_reg.baud_cnt - 12'h001;
    state_next.rdata    = 8'h00;

    // Register reads
    if (rd_i) begin
      case (addr_i)
        OFF_DATA:    state_next.rdata = rxc ? state_reg.fifo[0].data : 8'h00;
        OFF_CTRL_A:  state_next.rdata = {rxc, state_reg.txc, !state_reg.txb_full,
                                         rxc & state_reg.fifo[0].fe, state_reg.dor,
                                         rxc & state_reg.fifo[0].pe,
                                         state_reg.u2x, state_reg.mpcm};
        OFF_CTRL_B:  state_next.rdata = {state_reg.rxcie, state_reg.txcie, state_reg.udrie,
                                         state_reg.rxen, state_reg.txen, state_reg.csz2,
                                         rxc & state_reg.fifo[0].ninth, state_reg.txb8};
        OFF_CTRL_C:  state_next.rdata = {2'b00, state_reg.upm, state_reg.usbs,
                                         state_reg.csz_lo, 1'b0};
        OFF_BAUD_LO: state_next.rdata = state_reg.baud[7:0];
        OFF_BAUD_HI: state_next.rdata = {4'h0, state_reg.baud[11:8]};
        default:     state_next.rdata = 8'h00;
      endcase
    end

    // Transmitter release once drained
    if (!state_reg.txen && !state_reg.tx_busy && !state_reg.txb_full) begin
      state_next.tx_own = 1'b0;
    end

    // Transmit-complete clear by acknowledge
    if (tx_complete_ack_i) begin
      state_next.txc = 1'b0;
    end

    // Register writes
    if (wr_i) begin
      case (addr_i)
        OFF_DATA: begin
          if (!state_reg.txb_full) begin
            state_next.tx_buffer       = wdata_i;
            state_next.txb_ninth = state_reg.txb8;
            state_next.txb_full  = 1'b1;
          end
        end
        OFF_CTRL_A: begin
          state_next.u2x  = wdata_i[A_U2X];
          state_next.mpcm = wdata_i[A_MPCM];
          if (wdata_i[A_TXC]) begin
            state_next.txc = 1'b0;
          end
        end
        OFF_CTRL_B: begin
          state_next.rxcie = wdata_i[B_RXCIE];
          state_next.txcie = wdata_i[B_TXCIE];
          state_next.udrie = wdata_i[B_UDRIE];
          state_next.rxen  = wdata_i[B_RXEN];
          state_next.txen  = wdata_i[B_TXEN];
          state_next.csz2  = wdata_i[B_CSZ2];
          state_next.txb8  = wdata_i[B_TXB8];
          if (wdata_i[B_TXEN]) begin
            state_next.tx_own = 1'b1;
          end
        end
        OFF_CTRL_C: begin
          state_next.upm    = wdata_i[C_UPM1:C_UPM0];
          state_next.usbs   = wdata_i[C_USBS];
          state_next.csz_lo = wdata_i[C_CSZ1:C_CSZ0];
        end
        OFF_BAUD_LO: begin
          state_next.baud[7:0] = wdata_i;
          state_next.baud_cnt  = {state_reg.baud[11:8], wdata_i};
        end
        OFF_BAUD_HI: state_next.baud[11:8] = wdata_i[3:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // Transmit shifter
    // ----------------------------------------------------------------
    if (state_reg.tx_busy) begin
      if (tick) begin
        if (state_reg.tx_samp == ovs_last) begin
          state_next.tx_samp = 4'h0;
          state_next.tx_sh   = {1'b1, state_reg.tx_sh[12:1]};
          state_next.tx_left = state_reg.tx_left - 4'h1;
          if (tx_last) begin
            state_next.tx_busy = 1'b0;
            if (!state_next.txb_full) begin
              state_next.txc = 1'b1;
            end
          end
        end else begin
          state_next.tx_samp = state_reg.tx_samp + 4'h1;
        end
      end
    end else if (state_reg.tx_own && state_reg.txb_full) begin
      state_next.tx_sh    = frame;
      state_next.tx_left  = frame_len;
      state_next.tx_samp  = 4'h0;
      state_next.tx_busy  = 1'b1;
      state_next.txb_full = 1'b0;
    end

    // ----------------------------------------------------------------
    // Receive FIFO pop
    // ----------------------------------------------------------------
    if (rd_data && rxc) begin
      state_next.fifo[0] = state_reg.fifo[1];
      state_next.cnt     = state_reg.cnt - 2'h1;
      state_next.dor     = 1'b0;
    end

    // Held character enters FIFO when room appears
    if (state_reg.pend && (state_next.cnt != 2'h2)) begin
      state_next.fifo[state_next.cnt[0]] = state_reg.pend_e;
      state_next.cnt                     = state_next.cnt + 2'h1;
      state_next.pend                    = 1'b0;
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    unique case (state_reg.rx_st)
      RX_IDLE: begin
        if (state_reg.rxen && !state_reg.rx_s2) begin
          state_next.rx_st   = RX_START;
          state_next.rx_samp = 4'h0;
          state_next.rx_idx  = 4'h0;
          state_next.rx_drop = 1'b0;
          if ((state_reg.cnt == 2'h2) && state_reg.pend) begin
            state_next.dor     = 1'b1;
            state_next.rx_drop = 1'b1;
          end
        end
      end
      RX_START: begin
        if (tick) begin
          if (state_reg.rx_samp == ovs_half) begin
            state_next.rx_samp = 4'h0;
            state_next.rx_st   = state_reg.rx_s2 ? RX_IDLE : RX_DATA;
          end else begin
            state_next.rx_samp = state_reg.rx_samp + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          if (state_reg.rx_samp == ovs_last) begin
            state_next.rx_samp                   = 4'h0;
            state_next.rx_sh[state_reg.rx_idx]   = state_reg.rx_s2;
            state_next.rx_idx                    = state_reg.rx_idx + 4'h1;
            if (state_reg.rx_idx == rx_total - 4'h1) begin
              state_next.rx_st = RX_STOP;
            end
          end else begin
            state_next.rx_samp = state_reg.rx_samp + 4'h1;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          if (state_reg.rx_samp == ovs_last) begin
            state_next.rx_st = RX_IDLE;
          end else begin
            state_next.rx_samp = state_reg.rx_samp + 4'h1;
          end
        end
      end
    endcase

    // Completed character: FIFO, else hold in shifter
    if (rx_done && keep) begin
      if (state_next.cnt != 2'h2) begin
        state_next.fifo[state_next.cnt[0]] = '{data: rx_dat, ninth: rx_b8,
                                               fe: !state_reg.rx_s2, pe: rx_perr};
        state_next.cnt = state_next.cnt + 2'h1;
      end else begin
        state_next.pend   = 1'b1;
        state_next.pend_e = '{data: rx_dat, ninth: rx_b8, fe: !state_reg.rx_s2, pe: rx_perr};
      end
    end

    // Receiver off: flush and invalidate
    if (!state_reg.rxen) begin
      state_next.rx_st = RX_IDLE;
      state_next.cnt   = 2'h0;
      state_next.pend  = 1'b0;
      state_next.dor   = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o           = state_reg.rdata;
  assign serial_tx_pin_o   = state_reg.tx_sh[0];
  assign serial_tx_oe_o    = state_reg.tx_own;
  assign serial_rx_own_o   = state_reg.rxen;
  assign rx_complete_irq_o = state_reg.rxcie && global_irq_en_i && rxc;
  assign tx_complete_irq_o = state_reg.txcie && global_irq_en_i && state_reg.txc;
  assign tx_empty_irq_o    = state_reg.udrie && global_irq_en_i && !state_reg.txb_full;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  full_write_a: assert property (wr_data && state_reg.txb_full && !state_reg.tx_busy
                                 |=> state_reg.tx_buffer == $past(state_reg.tx_buffer))
    else $error("write to full transmit buffer changed it");
  data_capture_a: assert property (wr_data && !state_reg.txb_full
                                   |=> state_reg.txb_full && state_reg.tx_buffer == $past(wdata_i))
    else $error("data write not captured");
  rx_read_a: assert property (rd_data && rxc |=> rdata_o == $past(state_reg.fifo[0].data))
    else $error("data read did not return oldest character");
  rx_flush_a: assert property (!state_reg.rxen |=> !rxc && !state_reg.dor && !state_reg.pend)
    else $error("receiver disable did not flush");
  txc_set_a: assert property (tx_last && !state_reg.txb_full && !wr_data |=> state_reg.txc)
    else $error("transmit complete not set");
  txc_clear_a: assert property (wr_i && addr_i == OFF_CTRL_A && wdata_i[A_TXC] && !tx_last
                                |=> !state_reg.txc)
    else $error("transmit complete not cleared by one");
  tx_release_a: assert property (state_reg.tx_own && (state_reg.tx_busy || state_reg.txb_full)
                                 |=> state_reg.tx_own)
    else $error("transmit pin released while data pending");
  filter_drop_a: assert property (rx_done && state_reg.mpcm && !frame_type && !rd_data
                                  && !state_reg.pend |=> state_reg.cnt == $past(state_reg.cnt))
    else $error("data frame passed the multidrop filter");
  overrun_set_a: assert property (state_reg.rxen && state_reg.rx_st == RX_IDLE && !state_reg.rx_s2
                                  && state_reg.cnt == 2'h2 && state_reg.pend |=> state_reg.dor)
    else $error("overrun not flagged");
  upper_zero_a: assert property (rd_data && rxc && !state_reg.csz2 && state_reg.csz_lo != 2'h3
                                 ##1 $stable(data_mask) |-> (rdata_o & ~data_mask) == 8'h00)
    else $error("unused upper bits not zero");

  addr_frame_c: cover property (rx_done && state_reg.mpcm && frame_type);
  overrun_c:    cover property (state_reg.dor && rxc);
  tx_done_c:    cover property (tx_last ##1 state_reg.txc);

endmodule : umd_serial_core

`default_nettype wire

// file: tb/umd_node_model.sv
// Far serial node: sends frames, watches the tx line
`timescale 1ns/10ps
`default_nettype none
module umd_node_model (
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      line_o
);
  logic [7:0] last_byte = 8'h00;
  int         frames = 0;
  initial line_o = 1'b1;
  task automatic bit_out(input logic v);
    line_o <= v;
    repeat (16) @(posedge clk_i);
  endtask : bit_out
  task automatic send(input logic [8:0] d, input int nb, input logic two);
    @(posedge clk_i);
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    bit_out(1'b1);
    if (two) bit_out(1'b1);
    line_o <= 1'b1;
  endtask : send
  always begin
    @(negedge tx_i);
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk_i);
      last_byte[i] = tx_i;
    end
    repeat (16) @(posedge clk_i);
    frames++;
  end
endmodule : umd_node_model
`default_nettype wire

// file: tb/test_uart_data_status_multidrop.sv
// Self-checking bench of the multidrop serial core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module test_uart_data_status_multidrop;
  import umd_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] e;} umd_row_s;
  logic              clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, gie = 0, ack = 0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0]        wdata_i = '0, rdata_o;
  logic              tx, oe, own, irq_rx, irq_tc, irq_te, line;
  int                mismatches = 0, n_tests = 0;
  umd_row_s          rows [6] = '{'{OFF_CTRL_A, 8'hff, 8'h23}, '{OFF_CTRL_A, 8'h00, 8'h20},
    '{3'h6, 8'hff, 8'h00}, '{OFF_CTRL_B, 8'h1b, 8'h19}, '{OFF_CTRL_C, 8'h06, 8'h06},
    '{OFF_BAUD_LO, 8'h00, 8'h00}};
  always #10 clk_i = ~clk_i;
  umd_serial_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .global_irq_en_i(gie), .tx_complete_ack_i(ack),
    .serial_rx_pin_i(line), .serial_tx_pin_o(tx), .serial_tx_oe_o(oe), .serial_rx_own_o(own),
    .rx_complete_irq_o(irq_rx), .tx_complete_irq_o(irq_tc), .tx_empty_irq_o(irq_te));
  umd_node_model u_node (.clk_i(clk_i), .tx_i(tx), .line_o(line));
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata", e, rdata_o)
  endtask : rd
  task automatic rx(input logic [8:0] d, input int nb);
    u_node.send(d, nb, 1'b1);
    repeat (8) @(posedge clk_i);
  endtask : rx
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial begin
    #400us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(OFF_CTRL_A, CTRL_A_RESET);
    rd(OFF_CTRL_B, CTRL_B_RESET);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    wr(OFF_CTRL_C, 8'h04);
    rx(9'h1ff, 7);
    rd(OFF_CTRL_A, 8'ha0);
    rd(OFF_DATA, 8'h7f);
    rd(OFF_CTRL_A, 8'h20);
    wr(OFF_CTRL_C, 8'h06);
    wr(OFF_CTRL_B, 8'h1c);
    wr(OFF_CTRL_A, 8'h01);
    rx(9'h033, 9);
    rd(OFF_CTRL_A, 8'h21);
    rx(9'h15a, 9);
    rd(OFF_CTRL_A, 8'ha1);
    rd(OFF_CTRL_B, 8'h1e);
    rd(OFF_DATA, 8'h5a);
    wr(OFF_CTRL_B, 8'h18);
    for (int i = 0; i < 4; i++) rx(9'h0aa, 8);
    rd(OFF_CTRL_A, 8'ha9);
    wr(OFF_CTRL_B, 8'h48);
    rd(OFF_CTRL_A, 8'h21);
    gie <= 1'b1;
    @(posedge clk_i);
    addr_i <= OFF_DATA;
    wdata_i <= 8'h11;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wdata_i <= 8'h22;
    @(posedge clk_i);
    wr_i <= 1'b0;
    repeat (260) @(posedge clk_i);
    `CHK("tx_byte", 8'h11, u_node.last_byte)
    `CHK("frames", 1, u_node.frames)
    rd(OFF_CTRL_A, 8'h61);
    `CHK("tc_irq", 1'b1, irq_tc)
    wr(OFF_CTRL_A, 8'h41);
    rd(OFF_CTRL_A, 8'h21);
    wr(OFF_DATA, 8'h33);
    repeat (260) @(posedge clk_i);
    `CHK("tc_set", 1'b1, irq_tc)
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    rd(OFF_CTRL_A, 8'h21);
    print_verdict();
  end
endmodule : test_uart_data_status_multidrop
`default_nettype wire
